//--- src/fsx_pkg.sv
package fsx_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register addresses of the fault/status bank
    localparam logic [15:0] ADDR_STATUS = 16'h02BC;
    localparam logic [15:0] ADDR_RESERVED = 16'h02BD;
    localparam logic [15:0] ADDR_END = 16'h02BE;
    localparam logic [15:0] MAX_READ_QTY = 16'h007D;

    ////////////////////////////////////////////////////////////////////////
    // Function codes and diagnostic sub-functions
    localparam logic [7:0] FC_READ_COILS = 8'h01;
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [15:0] SFC_RET_DIAG = 16'h0002;
    localparam logic [15:0] SFC_CLR_DIAG = 16'h000A;

    ////////////////////////////////////////////////////////////////////////
    // Exception codes
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

    ////////////////////////////////////////////////////////////////////////
    // Status bit positions, defined-bit mask and reset value
    localparam int BIT_PARITY = 0;
    localparam int BIT_FRAMING = 1;
    localparam int BIT_TEMP_HI = 2;
    localparam int BIT_TEMP_LO = 3;
    localparam int BIT_MEAS_HI = 4;
    localparam int BIT_MEAS_LO = 5;
    localparam int BIT_CAL_FAIL = 6;
    localparam int BIT_NV_FAIL = 7;
    localparam int BIT_ACCEL = 8;
    localparam int BIT_TEST = 11;
    localparam int BIT_WDT = 12;
    localparam int BIT_BROWNOUT = 13;
    localparam logic [15:0] DEFINED_MASK = 16'h39FF;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Request from the frame decoder; for the diagnostic function the
    // address field holds the sub-function and the quantity field its data
    typedef struct packed {
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] qty;
    } fsx_req_t;

    // Answer towards the reply builder
    typedef struct packed {
        logic exc;
        logic [7:0] code;
        logic [1:0] nwords;
        logic [15:0] word0;
        logic [15:0] word1;
    } fsx_resp_t;

endpackage

//--- src/fsx_fault_status.sv
module fsx_fault_status #(
    parameter int MEAS_W = 16,
    parameter int TEMP_W = 16,
    parameter bit TEMP_AUTO_CLR = 1'b1
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    // Serial port error pulses
    input wire logic parity_err_in,
    input wire logic framing_err_in,
    input wire logic overrun_err_in,
    // Temperature and its calibrated limits
    input wire logic signed [TEMP_W-1:0] temp_in,
    input wire logic signed [TEMP_W-1:0] temp_max_in,
    input wire logic signed [TEMP_W-1:0] temp_min_in,
    // Measurement and its calibrated limits
    input wire logic meas_valid_in,
    input wire logic signed [MEAS_W-1:0] meas_in,
    input wire logic signed [MEAS_W-1:0] meas_max_in,
    input wire logic signed [MEAS_W-1:0] meas_min_in,
    // Load and self-test failure pulses
    input wire logic cal_load_fail_in,
    input wire logic nv_restore_fail_in,
    input wire logic accel_fail_in,
    // Test mode entry and exit command pulses
    input wire logic test_mode_enter_in,
    input wire logic test_mode_exit_command_in,
    // Reset cause levels, sampled just after reset release
    input wire logic wdt_cause_in,
    input wire logic brownout_cause_in,
    // Coil write pulses
    input wire logic comm_reset_coil_in,
    input wire logic sensor_reset_coil_in,
    // Request from the frame decoder
    input wire logic req_valid_in,
    input wire fsx_pkg::fsx_req_t req_in,
    // Answer and status outputs
    output logic resp_valid_out,
    output fsx_pkg::fsx_resp_t resp_out,
    output logic [15:0] status_out,
    output logic [15:0] mirror_msbf_out,
    output logic [15:0] mirror_lsbf_out,
    output logic signed [MEAS_W-1:0] meas_out
);
    import fsx_pkg::*;
    // Everything below runs on clk_in; rstn_in is sampled like any other input

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    // Range compares widen to 32 bits, so wider inputs would be cut,
    // and a one-bit signed value has no room for a positive limit
    if (MEAS_W < 2 || MEAS_W > 32) begin : g_meas_w_check
        $error("MEAS_W must lie in 2..32");
    end
    // Same limits hold for the temperature compare
    if (TEMP_W < 2 || TEMP_W > 32) begin : g_temp_w_check
        $error("TEMP_W must lie in 2..32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Swap the two bytes of a word
    // Feeds the lsb-first mirror
    function automatic logic [15:0] swap16(input logic [15:0] w);
        swap16 = {w[7:0], w[15:8]};
    endfunction

    // Signed greater-than on a 32-bit widened value
    // Shared by all four range compares
    function automatic logic gt32(input logic signed [31:0] a,
                                  input logic signed [31:0] b);
        gt32 = a > b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    // Fault/status word
    logic [15:0] status_q; // Held fault/status word
    logic [15:0] status_d; // Next fault/status word
    // Reset cause window
    logic start_q; // High in the first cycle after reset
    // Decoded clear and range compares
    logic diag_clr; // Diagnostic clear request taken
    logic temp_hi; // Temperature above maximum
    logic temp_lo; // Temperature below minimum
    logic meas_hi; // Measurement above maximum
    logic meas_lo; // Measurement below minimum
    // Range flags of the last sample, kept between samples
    logic meas_hi_q; // Held above-range flag
    logic meas_lo_q; // Held below-range flag
    // Answer path
    fsx_resp_t resp_d; // Next answer
    logic [16:0] last_addr; // Start plus quantity, one bit wider

    ////////////////////////////////////////////////////////////////////////
    // Range comparisons
    // Both sides are widened with their sign before comparing, so negative
    // limits work for any width; a value equal to a limit is still in range
    // and raises no flag
    always_comb begin
        temp_hi = gt32(32'(temp_in), 32'(temp_max_in));
        temp_lo = gt32(32'(temp_min_in), 32'(temp_in));
        meas_hi = gt32(32'(meas_in), 32'(meas_max_in));
        meas_lo = gt32(32'(meas_min_in), 32'(meas_in));
    end

    ////////////////////////////////////////////////////////////////////////
    // First-cycle marker for sampling the reset cause levels
    // The cause inputs only mean something right after a reboot; reading
    // them later would set the bits again after a diagnostic clear
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            // Armed for as long as reset is held
            start_q <= 1'b1;
        end else begin
            // Dropped after the first running edge
            start_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Diagnostic clear is a taken FC08 sub-function 10 request
    // The clear lands on the edge that takes the request, so the echo
    // and the cleared word appear together
    always_comb begin
        diag_clr = req_valid_in && req_in.func == FC_DIAG
                   && req_in.addr == SFC_CLR_DIAG;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clamped measurement and its range flags, updated per sample
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            meas_out <= '0;
            meas_hi_q <= 1'b0;
            meas_lo_q <= 1'b0;
        end else if (meas_valid_in) begin
            // Range flags only move on a new sample
            meas_hi_q <= meas_hi;
            meas_lo_q <= meas_lo;
            if (meas_hi) begin
                // Saturate at the positive limit
                meas_out <= meas_max_in;
            end else if (meas_lo) begin
                // Saturate at the negative limit
                meas_out <= meas_min_in;
            end else begin
                // In range: pass the sample through
                meas_out <= meas_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next status word: clears first, then sets, so a set wins
    always_comb begin
        status_d = status_q;
        // Communication reinitialise coil
        if (comm_reset_coil_in) begin
            status_d[BIT_PARITY] = 1'b0;
            status_d[BIT_FRAMING] = 1'b0;
        end
        // Diagnostic clear; load failures stay until a reboot
        // Bits 6 and 7 mark configuration faults that need a reboot to retry
        if (diag_clr) begin
            status_d[BIT_TEMP_HI] = 1'b0;
            status_d[BIT_TEMP_LO] = 1'b0;
            status_d[BIT_PARITY] = 1'b0;
            status_d[BIT_FRAMING] = 1'b0;
            status_d[BIT_ACCEL] = 1'b0;
            status_d[BIT_WDT] = 1'b0;
            status_d[BIT_BROWNOUT] = 1'b0;
        end
        // Sensor reset coil acts as a reboot
        // The reboot itself is reported through the watchdog bit below
        if (sensor_reset_coil_in) begin
            status_d[BIT_TEMP_HI] = 1'b0;
            status_d[BIT_TEMP_LO] = 1'b0;
            status_d[BIT_CAL_FAIL] = 1'b0;
            status_d[BIT_NV_FAIL] = 1'b0;
            status_d[BIT_ACCEL] = 1'b0;
            status_d[BIT_TEST] = 1'b0;
        end
        // Automatic clear of temperature flags when back in range
        if (TEMP_AUTO_CLR) begin
            status_d[BIT_TEMP_HI] = 1'b0;
            status_d[BIT_TEMP_LO] = 1'b0;
        end
        // Test mode exit command
        if (test_mode_exit_command_in) begin
            status_d[BIT_TEST] = 1'b0;
        end
        // Sets; placed after every clear so an event that meets a clear in
        // the same cycle is not lost
        if (parity_err_in) begin
            status_d[BIT_PARITY] = 1'b1;
        end
        if (framing_err_in || overrun_err_in) begin
            status_d[BIT_FRAMING] = 1'b1;
        end
        if (temp_hi) begin
            status_d[BIT_TEMP_HI] = 1'b1;
        end
        if (temp_lo) begin
            status_d[BIT_TEMP_LO] = 1'b1;
        end
        // Range flags follow the last sample
        status_d[BIT_MEAS_HI] = meas_valid_in ? meas_hi : meas_hi_q;
        status_d[BIT_MEAS_LO] = meas_valid_in ? meas_lo : meas_lo_q;
        if (cal_load_fail_in) begin
            status_d[BIT_CAL_FAIL] = 1'b1;
        end
        if (nv_restore_fail_in) begin
            status_d[BIT_NV_FAIL] = 1'b1;
        end
        if (accel_fail_in) begin
            status_d[BIT_ACCEL] = 1'b1;
        end
        if (test_mode_enter_in) begin
            status_d[BIT_TEST] = 1'b1;
        end
        // Reboot by coil or watchdog cause at start
        if (sensor_reset_coil_in || (start_q && wdt_cause_in)) begin
            status_d[BIT_WDT] = 1'b1;
        end
        if (start_q && brownout_cause_in) begin
            status_d[BIT_BROWNOUT] = 1'b1;
        end
        // Undefined bits forced low
        status_d = status_d & DEFINED_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // Status word and its mirrors
    // All three copies load from the same next value, so a reader never
    // sees them disagree
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            status_q <= STATUS_RESET;
            status_out <= STATUS_RESET;
            mirror_msbf_out <= STATUS_RESET;
            mirror_lsbf_out <= STATUS_RESET;
        end else begin
            status_q <= status_d;
            status_out <= status_d;
            mirror_msbf_out <= status_d;
            mirror_lsbf_out <= swap16(status_d);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request decode and exception selection
    always_comb begin
        resp_d = '0;
        last_addr = {1'b0, req_in.addr} + {1'b0, req_in.qty};
        case (req_in.func)
            FC_READ_HOLD, FC_READ_INPUT: begin
                // Zero, or more than one frame can carry, is a bad count
                if (req_in.qty == 16'h0000 || req_in.qty > MAX_READ_QTY) begin
                    resp_d.exc = 1'b1;
                    resp_d.code = EXC_ILL_VALUE;
                end else if (req_in.addr < ADDR_STATUS
                             || last_addr > {1'b0, ADDR_END}) begin
                    // Start below the bank or end past the reserved word
                    resp_d.exc = 1'b1;
                    resp_d.code = EXC_ILL_ADDR;
                end else if (req_in.addr == ADDR_STATUS) begin
                    // Word order: status, then reserved
                    resp_d.nwords = req_in.qty[1:0];
                    resp_d.word0 = status_q;
                    resp_d.word1 = 16'h0000;
                end else begin
                    // Reserved word alone
                    resp_d.nwords = 2'd1;
                    resp_d.word0 = 16'h0000;
                end
            end
            FC_DIAG: begin
                if (req_in.addr == SFC_RET_DIAG) begin
                    // The diagnostic register is the status word itself
                    resp_d.nwords = 2'd1;
                    resp_d.word0 = status_q;
                end else if (req_in.addr == SFC_CLR_DIAG) begin
                    // Echo of the data field
                    resp_d.nwords = 2'd1;
                    resp_d.word0 = req_in.qty;
                end else begin
                    // Sub-functions other than return and clear are not served
                    resp_d.exc = 1'b1;
                    resp_d.code = EXC_ILL_FUNC;
                end
            end
            default: begin
                // Writes and any other function on this range
                resp_d.exc = 1'b1;
                resp_d.code = EXC_ILL_FUNC;
            end
        endcase
        if (!resp_d.exc) begin
            // A normal answer carries no exception code
            resp_d.code = EXC_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered answer, one cycle after the request
    // The strobe lasts one cycle; the fields hold until the next answer
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            resp_valid_out <= 1'b0;
            resp_out <= '0;
        end else begin
            resp_valid_out <= req_valid_in;
            if (req_valid_in) begin
                resp_out <= resp_d;
            end
        end
    end

endmodule

//--- test/fsx_fault_status_asserts.sv
module fsx_fault_status_asserts
    import fsx_pkg::*;
#(
    parameter int MEAS_W = 16,
    parameter int TEMP_W = 16,
    parameter bit TEMP_AUTO_CLR = 1'b1
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic parity_err_in,
    input wire logic framing_err_in,
    input wire logic overrun_err_in,
    input wire logic sensor_reset_coil_in,
    input wire logic meas_valid_in,
    input wire logic signed [MEAS_W-1:0] meas_in,
    input wire logic signed [MEAS_W-1:0] meas_max_in,
    input wire logic req_valid_in,
    input wire fsx_pkg::fsx_req_t req_in,
    input wire logic resp_valid_out,
    input wire fsx_pkg::fsx_resp_t resp_out,
    input wire logic [15:0] status_out,
    input wire logic [15:0] mirror_msbf_out,
    input wire logic [15:0] mirror_lsbf_out,
    input wire logic signed [MEAS_W-1:0] meas_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // One clock domain, reset disables every check
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_resp;
        req_valid_in |=> resp_valid_out;
    endproperty
    a_resp: assert property (p_resp) else $error("answer missing");
    property p_quiet;
        !req_valid_in |=> !resp_valid_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_parity;
        parity_err_in |=> status_out[0];
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit not set");
    property p_frame;
        framing_err_in || overrun_err_in |=> status_out[1];
    endproperty
    a_frame: assert property (p_frame) else $error("framing bit not set");
    property p_undef;
        status_out[15:14] == 2'b00 && status_out[10:9] == 2'b00;
    endproperty
    a_undef: assert property (p_undef) else $error("undefined bit set");
    property p_mirror;
        mirror_msbf_out == status_out && mirror_lsbf_out == {status_out[7:0], status_out[15:8]};
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror differs");
    property p_write;
        req_valid_in && req_in.func == 8'h06 |=> resp_out.exc && resp_out.code == EXC_ILL_FUNC;
    endproperty
    a_write: assert property (p_write) else $error("write not refused");
    property p_zero;
        req_valid_in && req_in.func == FC_READ_INPUT && req_in.qty == 16'h0000
            |=> resp_out.exc && resp_out.code == EXC_ILL_VALUE;
    endproperty
    a_zero: assert property (p_zero) else $error("zero count accepted");
    property p_cal;
        status_out[6] && !sensor_reset_coil_in |=> status_out[6];
    endproperty
    a_cal: assert property (p_cal) else $error("table bit lost");
    property p_clamp;
        meas_valid_in && meas_in > meas_max_in
            |=> meas_out == $past(meas_max_in) && status_out[4];
    endproperty
    a_clamp: assert property (p_clamp) else $error("no clamp");
endmodule
bind fsx_fault_status fsx_fault_status_asserts #(.MEAS_W(MEAS_W), .TEMP_W(TEMP_W),
    .TEMP_AUTO_CLR(TEMP_AUTO_CLR)) fsx_chk (.*);

//--- test/fsx_master_model.sv
module fsx_master_model
    import fsx_pkg::*;
(
    input wire logic clk_in,
    output logic req_valid_out,
    output fsx_pkg::fsx_req_t req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle master, no request pending
    initial begin
        req_valid_out = 1'b0;
        req_out = '0;
    end
    // One decoded request, strobe held for exactly one edge
    task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
        @(posedge clk_in);
        req_valid_out <= 1'b1;
        req_out <= '{func: f, addr: a, qty: q};
        @(posedge clk_in);
        req_valid_out <= 1'b0;
        // Released fields must not look valid
        req_out <= ~req_out;
    endtask
endmodule

//--- test/fsx_fault_status_tb.sv
module fsx_fault_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fsx_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [10:0] ev = '0; // Event pulses
    logic wdt = 1'b0;
    logic bo = 1'b1;
    logic signed [15:0] temp = 16'sh0050;
    logic signed [15:0] meas = 16'sh0000;
    logic signed [15:0] tmax = 16'sh00F0; // Calibrated temperature limits
    logic signed [15:0] tmin = 16'sh0010;
    logic signed [15:0] mmax = 16'sh0400; // Calibrated measurement limits
    logic signed [15:0] mmin = 16'shFC00;
    logic req_valid;
    fsx_req_t req;
    logic resp_valid;
    fsx_resp_t resp;
    logic [15:0] status;
    logic [15:0] mir_m;
    logic [15:0] mir_l;
    logic signed [15:0] meas_o;
    int fails = 0;
    int compares = 0;
    logic [7:0] xf [9] = '{8'h03, 8'h03, 8'h04, 8'h04, 8'h03, 8'h06, 8'h10, 8'h08, 8'h05};
    logic [15:0] xa [9] = '{16'h02BD, 16'h02BC, 16'h02BE, 16'h02BC, 16'h02BC, 16'h02BC,
        16'h02BC, 16'h0005, 16'h0001};
    logic [15:0] xq [9] = '{16'h0001, 16'h0003, 16'h0001, 16'h0000, 16'h007E, 16'h0001,
        16'h0001, 16'h0000, 16'hFF00};
    logic [7:0] xc [9] = '{8'h00, 8'h02, 8'h02, 8'h03, 8'h03, 8'h01, 8'h01, 8'h01, 8'h01};
    always #50 clk_in = ~clk_in;
    fsx_master_model fsx_master_model_inst (.clk_in(clk_in), .req_valid_out(req_valid),
        .req_out(req));
    fsx_fault_status #(.MEAS_W(16), .TEMP_W(16), .TEMP_AUTO_CLR(1'b1)) fsx_fault_status_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .parity_err_in(ev[0]), .framing_err_in(ev[1]),
        .overrun_err_in(ev[2]), .temp_in(temp), .temp_max_in(tmax),
        .temp_min_in(tmin), .meas_valid_in(ev[10]), .meas_in(meas),
        .meas_max_in(mmax), .meas_min_in(mmin), .cal_load_fail_in(ev[3]),
        .nv_restore_fail_in(ev[4]), .accel_fail_in(ev[5]), .test_mode_enter_in(ev[6]),
        .test_mode_exit_command_in(ev[7]), .wdt_cause_in(wdt), .brownout_cause_in(bo),
        .comm_reset_coil_in(ev[8]), .sensor_reset_coil_in(ev[9]), .req_valid_in(req_valid),
        .req_in(req), .resp_valid_out(resp_valid), .resp_out(resp), .status_out(status),
        .mirror_msbf_out(mir_m), .mirror_lsbf_out(mir_l), .meas_out(meas_o));
    // Compare and count
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Status word and both mirrors
    task automatic st(input logic [15:0] e);
        chk("status", e, status);
        chk("mirror_msbf", e, mir_m);
        chk("mirror_lsbf", {e[7:0], e[15:8]}, mir_l);
    endtask
    // One-cycle event pulse, result visible after
    task automatic pulse(input int i);
        @(posedge clk_in);
        ev[i] <= 1'b1;
        @(posedge clk_in);
        ev[i] <= 1'b0;
        #1;
    endtask
    // Request and expected answer
    task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
        input logic [7:0] c, input logic [15:0] w0);
        fsx_master_model_inst.send(f, a, q);
        #1;
        chk("resp_valid", 16'h0001, {15'h0, resp_valid});
        chk("resp_code", {8'h00, c}, {8'h00, resp.code});
        chk("resp_exc", {15'h0, c != EXC_NONE}, {15'h0, resp.exc});
        if (c == EXC_NONE) begin
            chk("word0", w0, resp.word0);
        end
    endtask
    // Verdict and end of run
    task automatic print_verdict;
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard, tests need well under 400 cycles
    initial begin
        repeat (2000) @(posedge clk_in);
        fails++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        st(16'h2000);
        rq(FC_READ_HOLD, ADDR_STATUS, 16'h0002, EXC_NONE, 16'h2000);
        chk("nwords", 16'h0002, {14'h0, resp.nwords});
        chk("word1", 16'h0000, resp.word1);
        rq(FC_DIAG, SFC_CLR_DIAG, 16'h0000, EXC_NONE, 16'h0000);
        st(16'h0000);
        for (int i = 0; i < 7; i++) begin
            pulse(i);
        end
        st(16'h09C3);
        rq(FC_READ_INPUT, ADDR_STATUS, 16'h0001, EXC_NONE, 16'h09C3);
        rq(FC_DIAG, SFC_RET_DIAG, 16'h0000, EXC_NONE, 16'h09C3);
        pulse(8);
        st(16'h09C0);
        rq(FC_DIAG, SFC_CLR_DIAG, 16'h1234, EXC_NONE, 16'h1234);
        st(16'h08C0);
        pulse(7);
        st(16'h00C0);
        pulse(9);
        st(16'h1000);
        // Temperature leaves range high, then low, then returns
        @(posedge clk_in);
        temp <= 16'sh0100;
        repeat (2) @(posedge clk_in);
        #1;
        st(16'h1004);
        @(posedge clk_in);
        temp <= 16'sh0000;
        repeat (2) @(posedge clk_in);
        #1;
        st(16'h1008);
        @(posedge clk_in);
        temp <= 16'sh0050;
        repeat (2) @(posedge clk_in);
        #1;
        st(16'h1000);
        // Measurement above, then below range
        @(posedge clk_in);
        meas <= 16'sh0500;
        pulse(10);
        chk("meas", 16'h0400, meas_o);
        st(16'h1010);
        @(posedge clk_in);
        meas <= 16'shF000;
        pulse(10);
        chk("meas", 16'hFC00, meas_o);
        st(16'h1020);
        // Raised limit lets the same sample through unclamped
        @(posedge clk_in);
        meas <= 16'sh0500;
        mmax <= 16'sh0600;
        pulse(10);
        chk("meas", 16'h0500, meas_o);
        st(16'h1000);
        // Lowered temperature limit puts the same reading out of range
        @(posedge clk_in);
        tmax <= 16'sh0040;
        repeat (2) @(posedge clk_in);
        #1;
        st(16'h1004);
        @(posedge clk_in);
        tmax <= 16'sh00F0;
        repeat (2) @(posedge clk_in);
        #1;
        st(16'h1000);
        for (int i = 0; i < 9; i++) begin
            rq(xf[i], xa[i], xq[i], xc[i], 16'h0000);
        end
        // Second reset, now from the watchdog
        @(posedge clk_in);
        rstn_in <= 1'b0;
        wdt <= 1'b1;
        bo <= 1'b0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        st(16'h1000);
        print_verdict();
    end
endmodule
